// [ebcpb_pkg.sv]
`default_nettype none
package ebcpb_pkg;
    localparam int unsigned REF_CLK_HZ = 10_000_000;
    localparam int unsigned ACCESS_MIN_NS = 250;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / REF_CLK_HZ;
    localparam int unsigned ACCESS_MIN_CYC_I = (ACCESS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] ACCESS_MIN_CYC = 2'(ACCESS_MIN_CYC_I);
    localparam int unsigned KEY_BYTES = 8;
    localparam int unsigned KEY_ADDR_W = 3;
    localparam int unsigned SEQ_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam logic [SEQ_W-1:0] SEQ_RESET = 4'h0;
    localparam logic [SEQ_W-1:0] SEQ_LAST = 4'hf;
    localparam int unsigned REG_ADDR_W = 2;
    localparam logic [REG_ADDR_W-1:0] REG_ADDR_RESET = 2'h0;
    localparam int unsigned REG_SEL_LSB = 1;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    typedef enum logic {
        EBCPB_CMD_WRITE,
        EBCPB_CMD_READ
    } ebcpb_cmd_t;
endpackage
`default_nettype wire

// [ebcpb_if.sv]
`default_nettype none
interface ebcpb_if;
    import ebcpb_pkg::*;
    // Host side of the expansion bus
    logic cipher_select_n;
    logic key_counter_select_n;
    logic low_address_bit;
    logic io_write_cmd_n;
    logic io_read_cmd_n;
    logic host_wait_n;
    logic [DATA_W-1:0] host_wdata;
    logic [DATA_W-1:0] host_rdata;
    logic host_rdata_oe;

    modport device (
        input cipher_select_n, key_counter_select_n, low_address_bit,
        input io_write_cmd_n, io_read_cmd_n, host_wdata,
        output host_wait_n, host_rdata, host_rdata_oe
    );
    modport host (
        output cipher_select_n, key_counter_select_n, low_address_bit,
        output io_write_cmd_n, io_read_cmd_n, host_wdata,
        input host_wait_n, host_rdata, host_rdata_oe
    );
endinterface // ebcpb_if
`default_nettype wire

// [ebcpb_host.sv]
`default_nettype none
module ebcpb_host
    import ebcpb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    ebcpb_if.host bus,
    input wire logic req_valid,
    output logic req_ready,
    input wire ebcpb_pkg::ebcpb_cmd_t req_cmd,
    input wire logic req_odd,
    input wire logic req_key,
    input wire logic [ebcpb_pkg::DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [ebcpb_pkg::DATA_W-1:0] rsp_rdata
);
    import ebcpb_pkg::*;

    typedef enum logic [1:0] {HS_IDLE, HS_CMD, HS_END} ebcpb_hst_t;

    typedef struct packed {
        ebcpb_hst_t st;
        ebcpb_cmd_t cmd;
        logic odd;
        logic key;
        logic [DATA_W-1:0] wdata;
        logic rsp_valid;
        logic [DATA_W-1:0] rdata;
    } ebcpb_hstate_t;

    ebcpb_hstate_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp_valid = 1'b0;
        unique case (s_r.st)
            HS_IDLE: begin
                if (req_valid) begin
                    s_nxt.st = HS_CMD;
                    s_nxt.cmd = req_cmd;
                    s_nxt.odd = req_odd;
                    s_nxt.key = req_key;
                    s_nxt.wdata = req_wdata;
                end
            end
            HS_CMD: begin
                // Command held until the device releases wait
                if (bus.host_wait_n) begin
                    s_nxt.st = HS_END;
                    s_nxt.rdata = bus.host_rdata_oe ? bus.host_rdata : DATA_RESET;
                end
            end
            HS_END: begin
                s_nxt.st = HS_IDLE;
                s_nxt.rsp_valid = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '{st: HS_IDLE, cmd: EBCPB_CMD_WRITE, odd: 1'b0, key: 1'b0,
                     wdata: DATA_RESET, rsp_valid: 1'b0, rdata: DATA_RESET};
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    wire active = (s_r.st == HS_CMD);
    // select and command per cycle type
    assign bus.cipher_select_n = !(active && !s_r.key);
    assign bus.key_counter_select_n = !(active && s_r.key);
    assign bus.low_address_bit = s_r.odd;
    assign bus.io_write_cmd_n = !(active && s_r.cmd == EBCPB_CMD_WRITE);
    assign bus.io_read_cmd_n = !(active && s_r.cmd == EBCPB_CMD_READ);
    assign bus.host_wdata = s_r.wdata;
    assign req_ready = (s_r.st == HS_IDLE);
    assign rsp_valid = s_r.rsp_valid;
    assign rsp_rdata = s_r.rdata;
endmodule // ebcpb_host
`default_nettype wire

// [ebcpb_device.sv]
`default_nettype none
module ebcpb_device
    import ebcpb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    ebcpb_if.device bus,
    output logic addr_latch_strobe,
    output logic port_write_strobe_n,
    output logic port_read_strobe_n,
    output logic [ebcpb_pkg::DATA_W-1:0] port_wdata,
    input wire logic [ebcpb_pkg::DATA_W-1:0] port_rdata,
    output logic xcvr_to_host,
    output logic [ebcpb_pkg::REG_ADDR_W-1:0] latched_reg_addr,
    output logic latched_cipher_sel,
    output logic key_counter_clear_n,
    output logic key_counter_pulse_n,
    output logic aux_key_strobe_n,
    output logic [ebcpb_pkg::KEY_ADDR_W-1:0] key_byte_addr,
    output logic [ebcpb_pkg::KEY_BYTES-1:0] key_byte_sel_n,
    output logic counter_terminal_carry
);
    import ebcpb_pkg::*;

    typedef enum logic [2:0] {
        DS_IDLE, DS_ALE, DS_WR, DS_RD, DS_KEY, DS_DONE
    } ebcpb_dst_t;

    typedef struct packed {
        ebcpb_dst_t st;
        logic ale;
        logic wr_n;
        logic rd_n;
        logic [1:0] rd_cnt;
        logic [DATA_W-1:0] wdata;
        logic [REG_ADDR_W-1:0] reg_addr;
        logic cs_lat;
        logic clr_n;
        logic cp_n;
        logic [SEQ_W-1:0] seq;
    } ebcpb_dstate_t;

    ebcpb_dstate_t s_r, s_nxt;

    function automatic logic [KEY_BYTES-1:0] onehot_n(input logic [KEY_ADDR_W-1:0] a);
        onehot_n = ~(KEY_BYTES'(1) << a);
    endfunction

    typedef enum logic [2:0] {
        CYC_NONE, CYC_ALE, CYC_WR, CYC_RD, CYC_KEY
    } ebcpb_cyc_t;

    // Sorts a host command into one cycle kind; mixed selects or commands are refused
    function automatic ebcpb_cyc_t decode_cycle(input logic sel_c, input logic sel_k,
            input logic wr, input logic rd, input logic odd);
        decode_cycle = CYC_NONE;
        if (sel_c && !sel_k && wr && !rd) begin
            decode_cycle = odd ? CYC_WR : CYC_ALE;
        end else if (sel_c && !sel_k && rd && !wr && odd) begin
            decode_cycle = CYC_RD;
        end else if (sel_k && !sel_c && wr && !rd) begin
            decode_cycle = CYC_KEY;
        end
    endfunction

    wire cs = !bus.cipher_select_n;
    wire ks = !bus.key_counter_select_n;
    wire iow = !bus.io_write_cmd_n;
    wire ior = !bus.io_read_cmd_n;
    wire a0 = bus.low_address_bit;
    ebcpb_cyc_t cyc_kind;
    logic wait_req;
    assign cyc_kind = decode_cycle(cs, ks, iow, ior, a0);
    wire start_ale = (cyc_kind == CYC_ALE);
    wire start_wr = (cyc_kind == CYC_WR);
    wire start_rd = (cyc_kind == CYC_RD);
    wire start_key = (cyc_kind == CYC_KEY);
    wire carry = (s_r.seq == SEQ_LAST);

    always_comb begin
        s_nxt = s_r;
        s_nxt.clr_n = 1'b1;
        s_nxt.cp_n = 1'b1;
        if (!s_r.clr_n) begin
            s_nxt.seq = SEQ_RESET;
        end else if (!s_r.cp_n && !carry) begin
            s_nxt.seq = s_r.seq + 4'h1;
        end
        unique case (s_r.st)
            DS_IDLE: begin
                if (start_ale) begin
                    s_nxt.st = DS_ALE;
                    s_nxt.ale = 1'b1;
                    s_nxt.wdata = bus.host_wdata;
                end else if (start_wr) begin
                    s_nxt.st = DS_WR;
                    s_nxt.wr_n = 1'b0;
                    s_nxt.wdata = bus.host_wdata;
                end else if (start_rd) begin
                    s_nxt.st = DS_RD;
                    s_nxt.rd_n = 1'b0;
                    s_nxt.rd_cnt = ACCESS_MIN_CYC;
                end else if (start_key) begin
                    s_nxt.st = DS_KEY;
                    if (a0) begin
                        s_nxt.cp_n = 1'b0;
                    end else begin
                        s_nxt.clr_n = 1'b0;
                    end
                end
            end
            DS_ALE: begin
                // Falling strobe edge captures select and register address
                s_nxt.ale = 1'b0;
                s_nxt.reg_addr = s_r.wdata[REG_SEL_LSB +: REG_ADDR_W];
                s_nxt.cs_lat = 1'b1;
                s_nxt.st = DS_DONE;
            end
            DS_WR: begin
                s_nxt.wr_n = 1'b1;
                s_nxt.st = DS_DONE;
            end
            DS_RD: begin
                if (s_r.rd_cnt != 2'h0) begin
                    s_nxt.rd_cnt = s_r.rd_cnt - 2'h1;
                end
                if (!ior && s_r.rd_cnt == 2'h0) begin
                    s_nxt.rd_n = 1'b1;
                    s_nxt.st = DS_IDLE;
                end
            end
            DS_KEY: begin
                if (!iow) begin
                    s_nxt.st = DS_IDLE;
                end
            end
            DS_DONE: begin
                if (!iow && !ior) begin
                    s_nxt.st = DS_IDLE;
                end
            end
            default: begin
                s_nxt.st = DS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '{st: DS_IDLE, ale: 1'b0, wr_n: 1'b1, rd_n: 1'b1, rd_cnt: 2'h0,
                     wdata: DATA_RESET, reg_addr: REG_ADDR_RESET, cs_lat: 1'b0,
                     clr_n: 1'b1, cp_n: 1'b1, seq: SEQ_RESET};
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    // Wait is combinational from the decoded latch, write and read cycles so the host stalls at once; key cycles get no wait
    always_comb begin
        wait_req = 1'b0;
        unique case (s_r.st)
            DS_IDLE: begin
                wait_req = start_ale || start_wr || start_rd;
            end
            DS_ALE, DS_WR: begin
                wait_req = 1'b1;
            end
            DS_RD: begin
                wait_req = (s_r.rd_cnt != 2'h0);
            end
            default: begin
                wait_req = 1'b0;
            end
        endcase
    end
    assign bus.host_wait_n = !wait_req;
    assign bus.host_rdata = port_rdata;
    assign xcvr_to_host = !(bus.cipher_select_n || s_r.rd_n) == 1'b1 ? 1'b1 : 1'b0;
    assign bus.host_rdata_oe = xcvr_to_host;
    assign addr_latch_strobe = s_r.ale;
    assign port_write_strobe_n = s_r.wr_n;
    assign port_read_strobe_n = s_r.rd_n;
    assign port_wdata = s_r.wdata;
    assign latched_reg_addr = s_r.reg_addr;
    assign latched_cipher_sel = s_r.cs_lat;
    assign key_counter_clear_n = s_r.clr_n;
    assign key_counter_pulse_n = s_r.cp_n;
    assign aux_key_strobe_n = carry ? 1'b1 : s_r.seq[0];
    assign key_byte_addr = s_r.seq[SEQ_W-1:1];
    assign key_byte_sel_n = onehot_n(s_r.seq[SEQ_W-1:1]);
    assign counter_terminal_carry = carry;
endmodule // ebcpb_device
`default_nettype wire

// [ebcpb_sva.sv]
`default_nettype none
module ebcpb_sva
    import ebcpb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cipher_select_n,
    input wire logic key_counter_select_n,
    input wire logic low_address_bit,
    input wire logic io_write_cmd_n,
    input wire logic io_read_cmd_n,
    input wire logic host_wait_n,
    input wire logic host_rdata_oe,
    input wire logic addr_latch_strobe,
    input wire logic port_write_strobe_n,
    input wire logic port_read_strobe_n,
    input wire logic aux_key_strobe_n,
    input wire logic [ebcpb_pkg::KEY_BYTES-1:0] key_byte_sel_n,
    input wire logic counter_terminal_carry
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_ale_cause: assert property ($rose(addr_latch_strobe) |->
        !cipher_select_n && !io_write_cmd_n && !low_address_bit && key_counter_select_n)
        else $error("latch strobe without cause");
    a_ale_only: assert property (addr_latch_strobe |-> port_write_strobe_n && port_read_strobe_n)
        else $error("data strobe during latch");
    a_ale_single: assert property (addr_latch_strobe |=> !addr_latch_strobe)
        else $error("latch strobe too long");
    a_ale_wait: assert property (addr_latch_strobe |-> !host_wait_n)
        else $error("wait released early");
    a_wr_single: assert property ($fell(port_write_strobe_n) |=> port_write_strobe_n)
        else $error("write strobe too long");
    a_rd_wait: assert property ($fell(port_read_strobe_n) |-> (!host_wait_n) [*2])
        else $error("read wait too short");
    a_rd_hold: assert property (!port_read_strobe_n && !io_read_cmd_n |=> !port_read_strobe_n)
        else $error("read strobe ended early");
    a_xcvr_nor: assert property (host_rdata_oe == !(cipher_select_n || port_read_strobe_n))
        else $error("transceiver direction wrong");
    a_sel_onehot: assert property ($onehot(~key_byte_sel_n))
        else $error("byte select not one-hot");
    a_carry_block: assert property (counter_terminal_carry |-> aux_key_strobe_n)
        else $error("aux strobe after carry");
    c_latch: cover property (addr_latch_strobe);
    c_read: cover property ($fell(port_read_strobe_n));
    c_carry: cover property ($rose(counter_terminal_carry));
endmodule // ebcpb_sva
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ebcpb_pkg::*;
    logic ref_clk, resetn, clk_en, req_valid, req_ready, req_odd, req_key, rsp_valid;
    logic addr_latch_strobe, port_write_strobe_n, port_read_strobe_n, xcvr_to_host;
    logic latched_cipher_sel, key_counter_clear_n, key_counter_pulse_n, aux_key_strobe_n;
    logic counter_terminal_carry;
    ebcpb_cmd_t req_cmd;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, port_wdata, port_rdata;
    logic [REG_ADDR_W-1:0] latched_reg_addr;
    logic [KEY_ADDR_W-1:0] key_byte_addr;
    logic [KEY_BYTES-1:0] key_byte_sel_n;
    int err_count = 0, checks_done = 0, cyc = 0, n_ale = 0, n_wr = 0, n_cp = 0, n_clr = 0;
    ebcpb_if bus();
    ebcpb_host u_ebcpb_host(.ref_clk, .resetn, .clk_en, .bus(bus), .req_valid,
        .req_ready, .req_cmd, .req_odd, .req_key, .req_wdata, .rsp_valid, .rsp_rdata);
    ebcpb_device u_ebcpb_device(.ref_clk, .resetn, .clk_en, .bus(bus),
        .addr_latch_strobe, .port_write_strobe_n, .port_read_strobe_n, .port_wdata,
        .port_rdata, .xcvr_to_host, .latched_reg_addr, .latched_cipher_sel,
        .key_counter_clear_n, .key_counter_pulse_n, .aux_key_strobe_n, .key_byte_addr,
        .key_byte_sel_n, .counter_terminal_carry);
    ebcpb_sva u_ebcpb_sva(.ref_clk, .resetn, .cipher_select_n(bus.cipher_select_n),
        .key_counter_select_n(bus.key_counter_select_n), .low_address_bit(bus.low_address_bit),
        .io_write_cmd_n(bus.io_write_cmd_n), .io_read_cmd_n(bus.io_read_cmd_n),
        .host_wait_n(bus.host_wait_n), .host_rdata_oe(bus.host_rdata_oe), .addr_latch_strobe,
        .port_write_strobe_n, .port_read_strobe_n, .aux_key_strobe_n, .key_byte_sel_n,
        .counter_terminal_carry);
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Strobe pulse counters and hang limit
    always @(posedge ref_clk) begin
        cyc++;
        n_ale += int'(addr_latch_strobe);
        n_wr += int'(!port_write_strobe_n);
        n_cp += int'(!key_counter_pulse_n);
        n_clr += int'(!key_counter_clear_n);
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic xfer(ebcpb_cmd_t c, logic odd, logic key, logic [7:0] d);
        int n;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_cmd = c;
        req_odd = odd;
        req_key = key;
        req_wdata = d;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 100) check("handshake", 8'h00, 8'h01);
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic t_addr_write();
        int a0, w0;
        for (int a = 0; a < 4; a++) begin
            a0 = n_ale;
            w0 = n_wr;
            xfer(EBCPB_CMD_WRITE, 1'b0, 1'b0, 8'(a << 1));
            check("reg addr", 8'(latched_reg_addr), 8'(a));
            check("chip sel", 8'(latched_cipher_sel), 8'h01);
            check("latch pulses", 8'(n_ale - a0), 8'h01);
            check("write pulses", 8'(n_wr - w0), 8'h00);
            a0 = n_ale;
            w0 = n_wr;
            xfer(EBCPB_CMD_WRITE, 1'b1, 1'b0, 8'ha5 ^ 8'(a));
            check("wdata", port_wdata, 8'ha5 ^ 8'(a));
            check("wr pulses", 8'(n_wr - w0), 8'h01);
            check("no relatch", 8'(n_ale - a0), 8'h00);
            check("addr kept", 8'(latched_reg_addr), 8'(a));
        end
        $display("Test address and write done");
    endtask
    task automatic t_read();
        port_rdata = 8'h5a;
        xfer(EBCPB_CMD_READ, 1'b1, 1'b0, 8'h00);
        check("rdata", rsp_rdata, 8'h5a);
        check("rd strobe idle", 8'(port_read_strobe_n), 8'h01);
        check("xcvr idle", 8'(xcvr_to_host), 8'h00);
        $display("Test read done");
    endtask
    task automatic t_master_key();
        logic [7:0] kb;
        int w0;
        xfer(EBCPB_CMD_WRITE, 1'b0, 1'b0, 8'h04);
        w0 = n_wr;
        for (int i = 0; i < KEY_BYTES; i++) begin
            kb[7:1] = 7'(i * 19 + 1);
            kb[0] = ~^kb[7:1];
            xfer(EBCPB_CMD_WRITE, 1'b1, 1'b0, kb);
            check("key byte", port_wdata, kb);
            check("key parity", 8'(^port_wdata), 8'h01);
        end
        check("key writes", 8'(n_wr - w0), 8'(KEY_BYTES));
        check("key reg", 8'(latched_reg_addr), 8'h02);
        $display("Test master key done");
    endtask
    task automatic t_freeze();
        int c0, n;
        c0 = n_cp;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_cmd = EBCPB_CMD_WRITE;
        req_odd = 1'b1;
        req_key = 1'b1;
        @(negedge ref_clk);
        req_valid = 1'b0;
        clk_en = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("frozen pulses", 8'(n_cp - c0), 8'h00);
        clk_en = 1'b1;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (3) @(negedge ref_clk);
        check("thawed pulses", 8'(n_cp - c0), 8'h01);
        $display("Test clock enable done");
    endtask
    task automatic t_key();
        int c0;
        logic [3:0] s;
        repeat (3) xfer(EBCPB_CMD_WRITE, 1'b1, 1'b1, 8'h00);
        check("pre clear", 8'(key_byte_addr), 8'h01);
        c0 = n_clr;
        xfer(EBCPB_CMD_WRITE, 1'b0, 1'b1, 8'h00);
        check("cleared", 8'(key_byte_addr), 8'h00);
        check("clear pulses", 8'(n_clr - c0), 8'h01);
        check("strobe cleared", 8'(aux_key_strobe_n), 8'h00);
        for (int i = 1; i <= 16; i++) begin
            c0 = n_cp;
            xfer(EBCPB_CMD_WRITE, 1'b1, 1'b1, 8'h00);
            s = (i > 15) ? 4'hf : 4'(i);
            check("pulses", 8'(n_cp - c0), 8'h01);
            check("byte addr", 8'(key_byte_addr), 8'(s[3:1]));
            check("aux strobe", 8'(aux_key_strobe_n), 8'(s[0] | (s == 4'hf)));
            check("byte sel", key_byte_sel_n, ~(8'h01 << s[3:1]));
            check("carry", 8'(counter_terminal_carry), 8'(s == 4'hf));
        end
        $display("Test key load done");
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req_cmd = EBCPB_CMD_WRITE;
        req_odd = 1'b0;
        req_key = 1'b0;
        req_wdata = 8'h00;
        port_rdata = 8'h00;
        repeat (8) @(negedge ref_clk);
        resetn = 1'b1;
        t_addr_write();
        t_read();
        t_master_key();
        t_key();
        t_freeze();
        stop_test();
    end
endmodule // tb
`default_nettype wire
